// [logic/pwmtb_pkg.sv]
// Package for the PWM time base control block.
// Assumes an APB slave with 32-bit data and one word per register.
package pwmtb_pkg;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_PERIOD = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_MASK = 12'h00C;
  localparam logic [11:0] ADDR_COUNT = 12'h010;
  localparam int RUN_BIT = 15;
  localparam int IDLE_BIT = 13;
  localparam int POST_LSB = 4;
  localparam int PRE_LSB = 2;
  localparam int MODE_LSB = 0;
  localparam logic [15:0] CTRL_WMASK = 16'hA0FF;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [14:0] PERIOD_RESET = 15'h7FFF;
  localparam logic [1:0] MODE_FREE = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_UPDN = 2'h2;
  localparam logic [1:0] MODE_UPDN_DBL = 2'h3;
  localparam logic [5:0] PRE_DIV1 = 6'h00;
  localparam logic [5:0] PRE_DIV4 = 6'h03;
  localparam logic [5:0] PRE_DIV16 = 6'h0F;
  localparam logic [5:0] PRE_DIV64 = 6'h3F;
  localparam int EV_PERIOD = 0;
  localparam int EV_MID = 1;
  localparam int EV_SINGLE_DONE = 2;
  localparam int EV_W = 3;
endpackage : pwmtb_pkg

// [logic/pwmtb_top.sv]
// PWM time base with control register, period, counter and interrupts.
// Assumes an APB master on pclk; cpu_idle is a synchronous level on pclk.
// Notes on behaviour
// [RQ1] Time base counts while bit 15 is one and holds off while zero.
// [RQ2] With bit 13 set, time base halts while the CPU is idle.
// [RQ3] Bits 14 and 12 to 8 read zero and ignore writes.
// [RQ4] Bits 7 to 4 pick postscale 1:1 up to 1:16.
// [RQ5] Bits 3 to 2 pick prescale 1, 4, 16 or 64 cycles per count.
// [RQ6] Mode 00 counts up freely, wrapping at the period.
// [RQ7] Mode 01 runs one period then clears the enable bit.
// [RQ8] Mode 10 counts up to the period then down to zero, repeating.
// [RQ9] Mode 11 also raises an event at the top for a second update.
// [RQ10] Reset clears every writable control bit to zero.
// [RQ11] Postscaler counts periods and raises the period event per selected count.
module pwmtb_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic cpu_idle,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [14:0] tb_count,
  output logic tb_count_down,
  output logic irq
);
  typedef struct packed {
    logic [15:0] ctrl;
    logic [14:0] period;
    logic [14:0] count;
    logic down;
    logic [5:0] pre_cnt;
    logic [3:0] post_cnt;
    logic [pwmtb_pkg::EV_W-1:0] status;
    logic [pwmtb_pkg::EV_W-1:0] mask;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic irq;
  } pwmtb_state_t;

  pwmtb_state_t st_ff;
  pwmtb_state_t nxt_st;

  logic [1:0] mode;
  logic [3:0] post_sel;
  logic [5:0] pre_limit;
  logic tick;
  logic period_end;
  logic access;
  logic wr;
  logic [pwmtb_pkg::EV_W-1:0] ev;

  assign mode = st_ff.ctrl[pwmtb_pkg::MODE_LSB +: 2];
  assign post_sel = st_ff.ctrl[pwmtb_pkg::POST_LSB +: 4];
  assign access = psel && penable && !st_ff.ready;
  assign wr = access && pwrite;

  always_comb begin
    unique case (st_ff.ctrl[pwmtb_pkg::PRE_LSB +: 2])  // RQ5
      2'h0: pre_limit = pwmtb_pkg::PRE_DIV1;
      2'h1: pre_limit = pwmtb_pkg::PRE_DIV4;
      2'h2: pre_limit = pwmtb_pkg::PRE_DIV16;
      2'h3: pre_limit = pwmtb_pkg::PRE_DIV64;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    ev = '0;
    tick = 1'b0;
    period_end = 1'b0;
    nxt_st.ready = 1'b0;
    nxt_st.err = 1'b0;
    if (st_ff.ctrl[pwmtb_pkg::RUN_BIT] &&  // RQ1
        !(st_ff.ctrl[pwmtb_pkg::IDLE_BIT] && cpu_idle)) begin  // RQ2
      if (st_ff.pre_cnt >= pre_limit) begin
        nxt_st.pre_cnt = '0;
        tick = 1'b1;
      end else begin
        nxt_st.pre_cnt = st_ff.pre_cnt + 6'h01;
      end
    end else if (!st_ff.ctrl[pwmtb_pkg::RUN_BIT]) begin
      nxt_st.pre_cnt = '0;
    end
    if (tick) begin
      if (mode == pwmtb_pkg::MODE_FREE || mode == pwmtb_pkg::MODE_SINGLE) begin
        if (st_ff.count >= st_ff.period) begin  // RQ6
          nxt_st.count = '0;
          period_end = 1'b1;
          if (mode == pwmtb_pkg::MODE_SINGLE) begin
            nxt_st.ctrl[pwmtb_pkg::RUN_BIT] = 1'b0;  // RQ7
            ev[pwmtb_pkg::EV_SINGLE_DONE] = 1'b1;
          end
        end else begin
          nxt_st.count = st_ff.count + 15'h0001;
        end
        nxt_st.down = 1'b0;
      end else if (!st_ff.down) begin  // RQ8
        if (st_ff.count >= st_ff.period) begin
          nxt_st.down = 1'b1;
          nxt_st.count = st_ff.period - 15'h0001;
          if (mode == pwmtb_pkg::MODE_UPDN_DBL) begin
            ev[pwmtb_pkg::EV_MID] = 1'b1;  // RQ9
          end
        end else begin
          nxt_st.count = st_ff.count + 15'h0001;
        end
      end else begin
        if (st_ff.count == 15'h0000) begin
          nxt_st.down = 1'b0;
          nxt_st.count = 15'h0001;
          period_end = 1'b1;
        end else begin
          nxt_st.count = st_ff.count - 15'h0001;
        end
      end
    end
    if (period_end) begin
      if (st_ff.post_cnt >= post_sel) begin  // RQ4
        nxt_st.post_cnt = '0;  // RQ11
        ev[pwmtb_pkg::EV_PERIOD] = 1'b1;
      end else begin
        nxt_st.post_cnt = st_ff.post_cnt + 4'h1;  // RQ11
      end
    end
    if (access) begin
      nxt_st.ready = 1'b1;
      nxt_st.rdata = '0;
      unique case (paddr)
        pwmtb_pkg::ADDR_CTRL: begin
          nxt_st.rdata[15:0] = st_ff.ctrl;
          if (pwrite) begin
            nxt_st.ctrl = pwdata[15:0] & pwmtb_pkg::CTRL_WMASK;  // RQ3
            if (!pwdata[pwmtb_pkg::RUN_BIT]) begin
              nxt_st.count = '0;
              nxt_st.down = 1'b0;
              nxt_st.post_cnt = '0;
            end
          end
        end
        pwmtb_pkg::ADDR_PERIOD: begin
          nxt_st.rdata[14:0] = st_ff.period;
          if (pwrite) begin
            nxt_st.period = pwdata[14:0];
          end
        end
        pwmtb_pkg::ADDR_STATUS: begin
          nxt_st.rdata[pwmtb_pkg::EV_W-1:0] = st_ff.status;
        end
        pwmtb_pkg::ADDR_MASK: begin
          nxt_st.rdata[pwmtb_pkg::EV_W-1:0] = st_ff.mask;
          if (pwrite) begin
            nxt_st.mask = pwdata[pwmtb_pkg::EV_W-1:0];
          end
        end
        pwmtb_pkg::ADDR_COUNT: begin
          nxt_st.rdata[14:0] = st_ff.count;
        end
        default: begin
          nxt_st.err = 1'b1;
        end
      endcase
    end
    if (wr && paddr == pwmtb_pkg::ADDR_STATUS) begin
      nxt_st.status = (st_ff.status & ~pwdata[pwmtb_pkg::EV_W-1:0]) | ev;
    end else begin
      nxt_st.status = st_ff.status | ev;
    end
    nxt_st.irq = |(nxt_st.status & nxt_st.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.ctrl <= pwmtb_pkg::CTRL_RESET;  // RQ10
      st_ff.period <= pwmtb_pkg::PERIOD_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.rdata;
  assign pready = st_ff.ready;
  assign pslverr = st_ff.err;
  assign tb_count = st_ff.count;
  assign tb_count_down = st_ff.down;
  assign irq = st_ff.irq;
endmodule // pwmtb_top

// [dv/pwmtb_chk.sv]
// Checker for the PWM time base control block.
// Assumes binding to pwmtb_top; sees its ports only.
module pwmtb_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic cpu_idle,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [14:0] tb_count,
  input wire logic tb_count_down,
  input wire logic irq
);
  logic [15:0] ctrl_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_ff <= 16'h0000;
    else if (psel && penable && pready && pwrite && paddr == 12'h000) ctrl_ff <= pwdata[15:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready stuck");
  chk_err_unmapped: assert property (pready && !(paddr inside {12'h000, 12'h004, 12'h008,
    12'h00C, 12'h010}) |-> pslverr) else $error("pslverr missing");
  chk_err_mapped: assert property (pready && (paddr inside {12'h000, 12'h004, 12'h008,
    12'h00C, 12'h010}) |-> !pslverr) else $error("pslverr wrong");
  chk_ctrl_zeros: assert property (pready && !pwrite && paddr == 12'h000 |->
    (prdata & 32'hFFFF5F00) == 32'h0) else $error("reserved bits set");
  chk_stop_clear: assert property (pready && pwrite && paddr == 12'h000 && !pwdata[15]
    |=> (tb_count == 15'h0) [*2]) else $error("count not cleared");
  chk_idle_freeze: assert property ($past(cpu_idle && ctrl_ff[13]) |-> $stable(tb_count))
    else $error("count moved in idle");
  chk_down_mode: assert property (tb_count_down |-> ctrl_ff[1])
    else $error("down count in wrong mode");
  cover property (pslverr);
  cover property ($rose(tb_count_down));
  cover property ($rose(irq));
endmodule // pwmtb_chk
bind pwmtb_top pwmtb_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .cpu_idle, .prdata, .pready, .pslverr, .tb_count, .tb_count_down, .irq);

// [dv/tb_pwm_time_base_control.sv]
// Testbench for the PWM time base control block.
// Assumes pwmtb_top with its APB slave and the bound checker.
module tb_pwm_time_base_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cpu_idle = 0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, tb_count_down, irq;
  logic [14:0] tb_count, c;
  int err_count = 0, comparisons = 0, t;
  pwmtb_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .cpu_idle,
    .prdata, .pready, .pslverr, .tb_count, .tb_count_down, .irq);
  always #4 pclk = ~pclk;
  task test_done;
    if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h000, 32'h0);
    xfer(1'b1, 12'h000, 32'h7FFF);
    rdc(12'h000, 32'h20FF);
    xfer(1'b0, 12'h020, 32'h0);
    chk(32'(er), 32'h1);
    xfer(1'b1, 12'h004, 32'h3);
    for (int p = 0; p < 4; p++) begin
      xfer(1'b1, 12'h000, 32'h8000 | (p << 2));
      @(tb_count);
      t = $time;
      @(tb_count);
      chk(32'(($time - t) / 8), 32'h1 << (2 * p));
    end
    xfer(1'b1, 12'h000, 32'h0);
    chk(32'(tb_count), 32'h0);
    xfer(1'b1, 12'h00C, 32'h7);
    xfer(1'b1, 12'h000, 32'h8003);
    @(posedge tb_count_down);
    chk(32'(tb_count), 32'h2);
    repeat (20) @(posedge pclk);
    chk(32'(irq), 32'h1);
    xfer(1'b1, 12'h000, 32'h0);
    rdc(12'h008, 32'h3);
    xfer(1'b1, 12'h008, 32'h7);
    rdc(12'h008, 32'h0);
    chk(32'(irq), 32'h0);
    xfer(1'b1, 12'h00C, 32'h0);
    xfer(1'b1, 12'h000, 32'h8011);
    repeat (20) @(posedge pclk);
    chk(32'(irq), 32'h0);
    rdc(12'h000, 32'h11);
    rdc(12'h008, 32'h4);
    xfer(1'b1, 12'h00C, 32'h4);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h1);
    xfer(1'b1, 12'h000, 32'hA000);
    cpu_idle <= 1'b1;
    repeat (3) @(posedge pclk);
    c = tb_count;
    repeat (10) @(posedge pclk);
    chk(32'(tb_count), 32'(c));
    cpu_idle <= 1'b0;
    xfer(1'b1, 12'h000, 32'h8000);
    cpu_idle <= 1'b1;
    c = tb_count;
    repeat (10) @(posedge pclk);
    chk(32'(tb_count != c), 32'h1);
    test_done;
  end
  initial begin
    #100000;
    err_count++;
    test_done;
  end
endmodule // tb_pwm_time_base_control
